// >>> src/pcs_core.sv
// Program counter, return stack, flash partition checks and register slave
`timescale 1ns/1ns
`default_nettype none
module pcs_core (
  input  wire logic             CLK,
  input  wire logic             RSTN,
  input  wire logic             CE,
  input  wire pcs_pkg::pcs_cmd_t  CMD,
  input  wire pcs_pkg::pcs_cfg_t  CFG,
  input  wire pcs_pkg::pcs_wreq_t WREQ,
  output logic [20:0]           FETCH_ADDR,
  output logic                  FETCH_FAULT,
  output logic                  STACK_RESET,
  output logic                  WR_GRANT,
  input  wire logic [31:0]      S_AXI_AWADDR,
  input  wire logic             S_AXI_AWVALID,
  output logic                  S_AXI_AWREADY,
  input  wire logic [31:0]      S_AXI_WDATA,
  input  wire logic [3:0]       S_AXI_WSTRB,
  input  wire logic             S_AXI_WVALID,
  output logic                  S_AXI_WREADY,
  output logic [1:0]            S_AXI_BRESP,
  output logic                  S_AXI_BVALID,
  input  wire logic             S_AXI_BREADY,
  input  wire logic [31:0]      S_AXI_ARADDR,
  input  wire logic             S_AXI_ARVALID,
  output logic                  S_AXI_ARREADY,
  output logic [31:0]           S_AXI_RDATA,
  output logic [1:0]            S_AXI_RRESP,
  output logic                  S_AXI_RVALID,
  input  wire logic             S_AXI_RREADY
);
  logic        rst_meta_ff, rst_sync_ff, rst_n;
  logic [20:0] pc_ff,   nxt_pc;
  logic [7:0]  lath_ff, nxt_lath;
  logic [4:0]  latu_ff, nxt_latu;
  logic [6:0]  sp_ff,   nxt_sp;
  logic        ovf_ff,  nxt_ovf;
  logic        unf_ff,  nxt_unf;
  logic        werr_ff, nxt_werr;
  logic        srst_ff, nxt_srst;
  logic        wgnt_ff, nxt_wgnt;
  logic        bvalid_ff, nxt_bvalid;
  logic [1:0]  bresp_ff,  nxt_bresp;
  logic        rvalid_ff, nxt_rvalid;
  logic [1:0]  rresp_ff,  nxt_rresp;
  logic [31:0] rdata_ff,  nxt_rdata;
  logic [20:0] stack_mem [0:127];
  logic        stk_we;
  logic [6:0]  stk_wa;
  logic [20:0] stk_wd;
  logic [20:0] top_of_stack;
  logic        aw_hs, ar_hs, aw_map, ar_map, is_push, ovf_set, unf_set;
  logic        wr_prot;
  pcs_pkg::pcs_region_t wr_region;

  // Region of a program flash byte address
  function automatic pcs_pkg::pcs_region_t region_of(
    input logic [20:0] a, input pcs_pkg::pcs_cfg_t c);
    pcs_pkg::pcs_region_t r;
    r = pcs_pkg::REG_APP;
    if (!c.storage_region_enable_n &&
        a >= pcs_pkg::PFM_LAST - pcs_pkg::STOR_SPAN) begin
      r = pcs_pkg::REG_STOR;
    end else if (!c.boot_region_enable_n &&
                 a < (pcs_pkg::BOOT_UNIT << c.boot_region_size)) begin
      r = pcs_pkg::REG_BOOT;
    end
    return r;
  endfunction

  // Reset release through two flops
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  assign rst_n = rst_sync_ff;

  // Only the entry under the pointer is visible; entry zero reads zero
  assign top_of_stack = (sp_ff == pcs_pkg::SP_RST) ? pcs_pkg::PC_RST
                                          : stack_mem[sp_ff];

  assign aw_hs  = CE && S_AXI_AWVALID && S_AXI_WVALID && !bvalid_ff;
  assign ar_hs  = CE && S_AXI_ARVALID && !rvalid_ff;
  assign aw_map = (S_AXI_AWADDR[31:5] == 27'h0) &&
                  (S_AXI_AWADDR[1:0] == 2'h0);
  assign ar_map = (S_AXI_ARADDR[31:5] == 27'h0) &&
                  (S_AXI_ARADDR[1:0] == 2'h0);
  assign is_push = (CMD.op == pcs_pkg::OP_CALL) ||
                   (CMD.op == pcs_pkg::OP_INT_ACK) ||
                   (CMD.op == pcs_pkg::OP_PUSH);
  assign wr_region = region_of(WREQ.addr, CFG);

  always_comb begin
    unique case (wr_region)
      pcs_pkg::REG_BOOT: wr_prot = CFG.boot_write_protect;
      pcs_pkg::REG_STOR: wr_prot = CFG.storage_write_protect;
      pcs_pkg::REG_APP:  wr_prot = CFG.app_write_protect;
      default:           wr_prot = 1'b1;
    endcase
  end

  // Core next-state: sequencer command first, then bus effects
  always_comb begin
    nxt_pc   = pc_ff;
    nxt_lath = lath_ff;
    nxt_latu = latu_ff;
    nxt_sp   = sp_ff;
    nxt_srst = 1'b0;
    ovf_set  = 1'b0;
    unf_set  = 1'b0;
    stk_we   = 1'b0;
    stk_wa   = sp_ff;
    stk_wd   = pc_ff;
    unique case (CMD.op)
      pcs_pkg::OP_NONE: ;
      pcs_pkg::OP_STEP: nxt_pc = pc_ff + pcs_pkg::PC_STEP;
      pcs_pkg::OP_JUMP: nxt_pc = {CMD.target[20:1], 1'b0};
      pcs_pkg::OP_CALL, pcs_pkg::OP_INT_ACK, pcs_pkg::OP_PUSH: begin
        if (CMD.op != pcs_pkg::OP_PUSH) begin
          nxt_pc = {CMD.target[20:1], 1'b0};
        end
        if (sp_ff == pcs_pkg::SP_MAX) begin
          ovf_set = 1'b1;
          if (CFG.overflow_reset_enable) begin
            nxt_sp   = pcs_pkg::SP_RST;
            nxt_pc   = pcs_pkg::PC_RST;
            nxt_srst = 1'b1;
          end else begin
            stk_we = 1'b1;
            stk_wa = pcs_pkg::SP_MAX;
          end
        end else begin
          nxt_sp = sp_ff + 7'h01;
          stk_we = 1'b1;
          stk_wa = sp_ff + 7'h01;
        end
      end
      pcs_pkg::OP_RETURN: begin
        if (sp_ff == pcs_pkg::SP_RST) begin
          nxt_pc   = pcs_pkg::PC_RST;
          unf_set  = 1'b1;
          nxt_srst = CFG.overflow_reset_enable;
        end else begin
          nxt_pc = top_of_stack;
          nxt_sp = sp_ff - 7'h01;
        end
      end
      pcs_pkg::OP_POP: begin
        if (sp_ff != pcs_pkg::SP_RST) begin
          nxt_sp = sp_ff - 7'h01;
        end
      end
    endcase
    if (ar_hs && ar_map && S_AXI_ARADDR[7:0] == pcs_pkg::ADDR_PCL) begin
      nxt_lath = pc_ff[15:8];
      nxt_latu = pc_ff[20:16];
    end
    nxt_ovf  = ovf_ff;
    nxt_unf  = unf_ff;
    nxt_werr = werr_ff;
    if (aw_hs && aw_map && S_AXI_WSTRB[0]) begin
      unique case (S_AXI_AWADDR[7:0])
        pcs_pkg::ADDR_PCL:
          nxt_pc = {latu_ff, lath_ff, S_AXI_WDATA[7:1], 1'b0};
        pcs_pkg::ADDR_LATH: nxt_lath = S_AXI_WDATA[7:0];
        pcs_pkg::ADDR_LATU: nxt_latu = S_AXI_WDATA[4:0];
        pcs_pkg::ADDR_SP:   nxt_sp   = S_AXI_WDATA[6:0];
        pcs_pkg::ADDR_TOP_ENTRY_LOW, pcs_pkg::ADDR_TOP_ENTRY_HIGH, pcs_pkg::ADDR_TOP_ENTRY_UPPER: begin
          if (sp_ff != pcs_pkg::SP_RST) begin
            stk_we = 1'b1;
            stk_wa = sp_ff;
            stk_wd = top_of_stack;
            if (S_AXI_AWADDR[7:0] == pcs_pkg::ADDR_TOP_ENTRY_LOW) begin
              stk_wd[7:0] = S_AXI_WDATA[7:0];
            end else if (S_AXI_AWADDR[7:0] == pcs_pkg::ADDR_TOP_ENTRY_HIGH) begin
              stk_wd[15:8] = S_AXI_WDATA[7:0];
            end else begin
              stk_wd[20:16] = S_AXI_WDATA[4:0];
            end
          end
        end
        pcs_pkg::ADDR_STAT: begin
          nxt_ovf  = S_AXI_WDATA[pcs_pkg::STAT_OVF];
          nxt_unf  = S_AXI_WDATA[pcs_pkg::STAT_UNF];
          nxt_werr = S_AXI_WDATA[pcs_pkg::STAT_WERR];
        end
        default: ;
      endcase
    end
    nxt_wgnt = WREQ.req && !wr_prot;
    // Hardware set wins over a software clear
    nxt_ovf  = nxt_ovf | ovf_set;
    nxt_unf  = nxt_unf | unf_set;
    nxt_werr = nxt_werr | (WREQ.req && wr_prot);
  end

  // Bus answers
  always_comb begin
    nxt_bvalid = bvalid_ff;
    nxt_bresp  = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rresp  = rresp_ff;
    nxt_rdata  = rdata_ff;
    if (bvalid_ff && S_AXI_BREADY) begin
      nxt_bvalid = 1'b0;
    end
    if (aw_hs) begin
      nxt_bvalid = 1'b1;
      nxt_bresp  = aw_map ? pcs_pkg::RESP_OKAY : pcs_pkg::RESP_SLVERR;
    end
    if (rvalid_ff && S_AXI_RREADY) begin
      nxt_rvalid = 1'b0;
    end
    if (ar_hs) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = ar_map ? pcs_pkg::RESP_OKAY : pcs_pkg::RESP_SLVERR;
      nxt_rdata  = 32'h0;
      if (ar_map) begin
        unique case (S_AXI_ARADDR[7:0])
          pcs_pkg::ADDR_PCL:  nxt_rdata[7:0] = pc_ff[7:0];
          pcs_pkg::ADDR_LATH: nxt_rdata[7:0] = lath_ff;
          pcs_pkg::ADDR_LATU: nxt_rdata[4:0] = latu_ff;
          pcs_pkg::ADDR_SP:   nxt_rdata[6:0] = sp_ff;
          pcs_pkg::ADDR_TOP_ENTRY_LOW: nxt_rdata[7:0] = top_of_stack[7:0];
          pcs_pkg::ADDR_TOP_ENTRY_HIGH: nxt_rdata[7:0] = top_of_stack[15:8];
          pcs_pkg::ADDR_TOP_ENTRY_UPPER: nxt_rdata[4:0] = top_of_stack[20:16];
          pcs_pkg::ADDR_STAT:
            nxt_rdata[2:0] = {werr_ff, unf_ff, ovf_ff};
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      pc_ff     <= pcs_pkg::PC_RST;
      lath_ff   <= pcs_pkg::LAT_RST;
      latu_ff   <= pcs_pkg::LATU_RST;
      sp_ff     <= pcs_pkg::SP_RST;
      ovf_ff    <= 1'b0;
      unf_ff    <= 1'b0;
      werr_ff   <= 1'b0;
      srst_ff   <= 1'b0;
      wgnt_ff   <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= pcs_pkg::RESP_OKAY;
      rvalid_ff <= 1'b0;
      rresp_ff  <= pcs_pkg::RESP_OKAY;
      rdata_ff  <= 32'h0;
    end else if (CE) begin
      pc_ff     <= nxt_pc;
      lath_ff   <= nxt_lath;
      latu_ff   <= nxt_latu;
      sp_ff     <= nxt_sp;
      ovf_ff    <= nxt_ovf;
      unf_ff    <= nxt_unf;
      werr_ff   <= nxt_werr;
      srst_ff   <= nxt_srst;
      wgnt_ff   <= nxt_wgnt;
      bvalid_ff <= nxt_bvalid;
      bresp_ff  <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rresp_ff  <= nxt_rresp;
      rdata_ff  <= nxt_rdata;
    end
  end

  // Stack storage, entry zero is never written
  always_ff @(posedge CLK) begin
    if (CE && stk_we) begin
      stack_mem[stk_wa] <= stk_wd;
    end
  end

  assign FETCH_ADDR    = pc_ff;
  assign FETCH_FAULT   = region_of(pc_ff, CFG) == pcs_pkg::REG_STOR;
  assign STACK_RESET   = srst_ff;
  assign WR_GRANT      = wgnt_ff;
  assign S_AXI_AWREADY = aw_hs;
  assign S_AXI_WREADY  = aw_hs;
  assign S_AXI_BVALID  = bvalid_ff;
  assign S_AXI_BRESP   = bresp_ff;
  assign S_AXI_ARREADY = ar_hs;
  assign S_AXI_RVALID  = rvalid_ff;
  assign S_AXI_RRESP   = rresp_ff;
  assign S_AXI_RDATA   = rdata_ff;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);

  chk_pc_aligned: assert property (pc_ff[0] == 1'b0)
    else $error("counter bit zero is set");
  chk_step_by_two: assert property (CE && CMD.op == pcs_pkg::OP_STEP &&
    !aw_hs |=> pc_ff == $past(pc_ff) + pcs_pkg::PC_STEP)
    else $error("sequential fetch did not add two");
  chk_push_inc: assert property (CE && is_push && !aw_hs &&
    sp_ff != pcs_pkg::SP_MAX |=> sp_ff == $past(sp_ff) + 7'h01)
    else $error("push did not increment pointer");
  chk_pop_dec: assert property (CE && CMD.op == pcs_pkg::OP_RETURN &&
    !aw_hs && sp_ff != pcs_pkg::SP_RST
    |=> sp_ff == $past(sp_ff) - 7'h01 && pc_ff == $past(top_of_stack))
    else $error("return did not pop the top entry");
  chk_ovf_set: assert property (CE && is_push &&
    sp_ff == pcs_pkg::SP_MAX |=> ovf_ff)
    else $error("overflow flag not set");
  chk_ovf_reset: assert property (CE && is_push && !aw_hs &&
    sp_ff == pcs_pkg::SP_MAX && CFG.overflow_reset_enable
    |=> STACK_RESET && sp_ff == pcs_pkg::SP_RST ##1 !STACK_RESET)
    else $error("overflow reset missing");
  chk_ovf_hold: assert property (CE && is_push && !aw_hs &&
    sp_ff == pcs_pkg::SP_MAX && !CFG.overflow_reset_enable
    |=> !STACK_RESET && sp_ff == pcs_pkg::SP_MAX)
    else $error("pointer left 127 on overflow");
  chk_unf_empty: assert property (CE && CMD.op == pcs_pkg::OP_RETURN &&
    !aw_hs && sp_ff == pcs_pkg::SP_RST
    |=> unf_ff && pc_ff == pcs_pkg::PC_RST &&
        STACK_RESET == $past(CFG.overflow_reset_enable))
    else $error("empty pop handled wrongly");
  chk_pcl_load: assert property (aw_hs && aw_map && S_AXI_WSTRB[0] &&
    S_AXI_AWADDR[7:0] == pcs_pkg::ADDR_PCL
    |=> pc_ff[20:8] == {$past(latu_ff), $past(lath_ff)})
    else $error("low byte write did not load latches");
  chk_call_latch: assert property (CE && CMD.op == pcs_pkg::OP_CALL &&
    !aw_hs && !ar_hs |=> $stable(lath_ff) && $stable(latu_ff))
    else $error("call changed a latch");
  chk_wr_protect: assert property (CE && WREQ.req && wr_prot
    |=> werr_ff && !WR_GRANT)
    else $error("protected write not refused");
  chk_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY
    |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");

  cov_overflow: cover property (ovf_set && CE);
  cov_underflow: cover property (unf_set && CE);
  cov_pcl_write: cover property (aw_hs && S_AXI_AWADDR[7:0] == 8'h00);
  cov_wr_error: cover property (CE && WREQ.req && wr_prot);
endmodule // pcs_core
`default_nettype wire

// >>> src/pcs_pkg.sv
// Shared constants and types for the program counter and return stack
package pcs_pkg;
  localparam int          PC_W        = 21;
  localparam int          SP_W        = 7;
  localparam logic [6:0]  SP_RST      = 7'h00;
  localparam logic [6:0]  SP_MAX      = 7'h7F;
  localparam logic [20:0] PC_RST      = 21'h000000;
  localparam logic [20:0] PC_STEP     = 21'h000002;
  localparam logic [20:0] PFM_LAST    = 21'h01FFFF;
  localparam logic [20:0] STOR_SPAN   = 21'h0000FF;
  localparam logic [20:0] BOOT_UNIT   = 21'h000400;
  localparam logic [7:0]  LAT_RST     = 8'h00;
  localparam logic [4:0]  LATU_RST    = 5'h00;
  // Register byte offsets
  localparam logic [7:0]  ADDR_PCL    = 8'h00;
  localparam logic [7:0]  ADDR_LATH   = 8'h04;
  localparam logic [7:0]  ADDR_LATU   = 8'h08;
  localparam logic [7:0]  ADDR_SP     = 8'h0C;
  localparam logic [7:0]  ADDR_TOP_ENTRY_LOW   = 8'h10;
  localparam logic [7:0]  ADDR_TOP_ENTRY_HIGH   = 8'h14;
  localparam logic [7:0]  ADDR_TOP_ENTRY_UPPER   = 8'h18;
  localparam logic [7:0]  ADDR_STAT   = 8'h1C;
  // Status register bits
  localparam int          STAT_OVF    = 0;
  localparam int          STAT_UNF    = 1;
  localparam int          STAT_WERR   = 2;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    OP_NONE, OP_STEP, OP_JUMP, OP_CALL, OP_INT_ACK, OP_RETURN, OP_PUSH, OP_POP
  } pcs_op_t;

  typedef enum logic [1:0] {REG_APP, REG_BOOT, REG_STOR} pcs_region_t;

  typedef struct packed {
    pcs_op_t     op;
    logic [20:0] target;
  } pcs_cmd_t;

  typedef struct packed {
    logic       overflow_reset_enable;
    logic       boot_region_enable_n;
    logic       storage_region_enable_n;
    logic [2:0] boot_region_size;
    logic       app_write_protect;
    logic       boot_write_protect;
    logic       storage_write_protect;
  } pcs_cfg_t;

  typedef struct packed {
    logic        req;
    logic [20:0] addr;
  } pcs_wreq_t;
endpackage

// >>> testbench/pcs_seq_model.sv
// Sequencer model that presents one command per request
`timescale 1ns/1ns
`default_nettype none
module pcs_seq_model (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             req,
  input  wire pcs_pkg::pcs_op_t req_op,
  input  wire logic [20:0]      req_tgt,
  input  wire logic             int_mask,
  output var pcs_pkg::pcs_cmd_t cmd
);
  // Interrupt acknowledges dropped while software owns the stack
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmd <= '{pcs_pkg::OP_NONE, 21'h000000};
    end else if (req &&
                 !(int_mask && req_op == pcs_pkg::OP_INT_ACK)) begin
      cmd <= '{req_op, req_tgt};
    end else begin
      cmd <= '{pcs_pkg::OP_NONE, 21'h000000};
    end
  end
endmodule // pcs_seq_model
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking testbench for the program counter and return stack
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    n_compared++; \
    if ((g) !== (e)) begin \
      error_cnt++; \
      $display("unexpected %s exp %0h got %0h", nm, e, g); \
    end \
  end
module testbench;
  logic               clk;
  logic               rstn;
  logic               req;
  logic               int_mask;
  pcs_pkg::pcs_op_t   req_op;
  logic [20:0]        req_tgt;
  pcs_pkg::pcs_cmd_t  cmd;
  pcs_pkg::pcs_cfg_t  cfg;
  pcs_pkg::pcs_wreq_t wreq;
  logic [20:0]        fetch_addr;
  logic               fetch_fault, stack_reset, wr_grant;
  logic [31:0]        awaddr, wdata, araddr, rdata, rd;
  logic               awvalid, awready, wvalid, wready, bvalid, bready;
  logic               arvalid, arready, rvalid, rready;
  logic [1:0]         bresp, rresp, rsp;
  int                 error_cnt, n_compared, rst_cnt, grant_cnt;

  pcs_seq_model seq_u (.clk(clk), .rstn(rstn), .req(req), .req_op(req_op),
    .req_tgt(req_tgt), .int_mask(int_mask), .cmd(cmd));
  pcs_core dut_u (.CLK(clk), .RSTN(rstn), .CE(1'b1), .CMD(cmd), .CFG(cfg),
    .WREQ(wreq), .FETCH_ADDR(fetch_addr), .FETCH_FAULT(fetch_fault),
    .STACK_RESET(stack_reset), .WR_GRANT(wr_grant),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Count one-cycle pulses mid-cycle
  always @(negedge clk) begin
    if (stack_reset === 1'b1) rst_cnt++;
    if (wr_grant === 1'b1) grant_cnt++;
  end

  task automatic close_out();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic await(ref logic s);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (s !== 1'b1 && n < 50);
    if (s !== 1'b1) begin
      `CHK("handshake", 1'b1, s)
      close_out();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    awaddr <= {24'h000000, a};
    wdata <= {24'h000000, d};
    {awvalid, wvalid, bready} <= 3'h7;
    await(awready);
    @(posedge clk);
    {awvalid, wvalid} <= 2'h0;
    await(bvalid);
    rsp = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e,
                        input string nm);
    @(posedge clk);
    araddr <= {24'h000000, a};
    {arvalid, rready} <= 2'h3;
    await(arready);
    @(posedge clk);
    arvalid <= 1'b0;
    await(rvalid);
    rd = rdata;
    rsp = rresp;
    @(posedge clk);
    rready <= 1'b0;
    `CHK(nm, {24'h000000, e}, rd)
  endtask

  task automatic do_op(input pcs_pkg::pcs_op_t o, input logic [20:0] t);
    @(posedge clk);
    req <= 1'b1;
    req_op <= o;
    req_tgt <= t;
    @(posedge clk);
    req <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    #1;
  endtask

  task automatic flc(input logic [20:0] a, input logic ok);
    int g;
    g = grant_cnt;
    @(posedge clk);
    wreq <= '{1'b1, a};
    @(posedge clk);
    wreq <= '{1'b0, a};
    repeat (3) @(posedge clk);
    `CHK("write grant", ok, grant_cnt - g)
    rd_chk(pcs_pkg::ADDR_STAT, ok ? 8'h00 : 8'h04, "write error");
    wr(pcs_pkg::ADDR_STAT, 8'h00);
  endtask

  initial begin
    {error_cnt, n_compared, rst_cnt, grant_cnt} = '0;
    {rstn, req, int_mask, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, wdata, araddr, req_tgt} = '0;
    req_op = pcs_pkg::OP_NONE;
    wreq = '0;
    cfg = '0;
    cfg.boot_region_enable_n = 1'b1;
    cfg.storage_region_enable_n = 1'b1;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(pcs_pkg::ADDR_SP, 8'h00, "pointer");
    do_op(pcs_pkg::OP_STEP, 21'h000000);
    `CHK("counter", 21'h000002, fetch_addr)
    wr(pcs_pkg::ADDR_LATH, 8'h12);
    wr(pcs_pkg::ADDR_LATU, 8'h03);
    wr(pcs_pkg::ADDR_PCL, 8'h35);
    @(negedge clk);
    `CHK("counter", 21'h031234, fetch_addr)
    do_op(pcs_pkg::OP_JUMP, 21'h0ABCD6);
    `CHK("counter", 21'h0ABCD6, fetch_addr)
    rd_chk(pcs_pkg::ADDR_LATH, 8'h12, "high latch");
    rd_chk(pcs_pkg::ADDR_PCL, 8'hD6, "low byte");
    rd_chk(pcs_pkg::ADDR_LATH, 8'hBC, "high latch");
    rd_chk(pcs_pkg::ADDR_LATU, 8'h0A, "upper latch");
    do_op(pcs_pkg::OP_CALL, 21'h001000);
    `CHK("counter", 21'h001000, fetch_addr)
    rd_chk(pcs_pkg::ADDR_SP, 8'h01, "pointer");
    rd_chk(pcs_pkg::ADDR_TOP_ENTRY_LOW, 8'hD6, "entry low");
    rd_chk(pcs_pkg::ADDR_TOP_ENTRY_HIGH, 8'hBC, "entry high");
    rd_chk(pcs_pkg::ADDR_TOP_ENTRY_UPPER, 8'h0A, "entry upper");
    rd_chk(pcs_pkg::ADDR_LATU, 8'h0A, "upper latch");
    int_mask <= 1'b1;
    wr(pcs_pkg::ADDR_TOP_ENTRY_LOW, 8'h20);
    wr(pcs_pkg::ADDR_TOP_ENTRY_HIGH, 8'h05);
    wr(pcs_pkg::ADDR_TOP_ENTRY_UPPER, 8'h01);
    int_mask <= 1'b0;
    do_op(pcs_pkg::OP_RETURN, 21'h000000);
    `CHK("counter", 21'h010520, fetch_addr)
    rd_chk(pcs_pkg::ADDR_SP, 8'h00, "pointer");
    do_op(pcs_pkg::OP_INT_ACK, 21'h000008);
    `CHK("counter", 21'h000008, fetch_addr)
    rd_chk(pcs_pkg::ADDR_TOP_ENTRY_LOW, 8'h20, "entry low");
    do_op(pcs_pkg::OP_RETURN, 21'h000000);
    do_op(pcs_pkg::OP_PUSH, 21'h000000);
    rd_chk(pcs_pkg::ADDR_TOP_ENTRY_HIGH, 8'h05, "entry high");
    do_op(pcs_pkg::OP_POP, 21'h000000);
    `CHK("counter", 21'h010520, fetch_addr)
    rd_chk(pcs_pkg::ADDR_SP, 8'h00, "pointer");
    do_op(pcs_pkg::OP_RETURN, 21'h000000);
    `CHK("counter", 21'h000000, fetch_addr)
    `CHK("reset pulses", 0, rst_cnt)
    rd_chk(pcs_pkg::ADDR_STAT, 8'h02, "status");
    wr(pcs_pkg::ADDR_STAT, 8'h00);
    for (int i = 0; i < 129; i++) begin
      do_op(pcs_pkg::OP_CALL, 21'((i + 1) * 4));
    end
    rd_chk(pcs_pkg::ADDR_SP, 8'h7F, "pointer");
    rd_chk(pcs_pkg::ADDR_STAT, 8'h01, "status");
    rd_chk(pcs_pkg::ADDR_TOP_ENTRY_HIGH, 8'h02, "entry high");
    `CHK("reset pulses", 0, rst_cnt)
    wr(pcs_pkg::ADDR_STAT, 8'h00);
    rd_chk(pcs_pkg::ADDR_STAT, 8'h00, "status");
    cfg.overflow_reset_enable <= 1'b1;
    wr(pcs_pkg::ADDR_SP, 8'h7F);
    do_op(pcs_pkg::OP_CALL, 21'h000040);
    `CHK("reset pulses", 1, rst_cnt)
    `CHK("counter", 21'h000000, fetch_addr)
    rd_chk(pcs_pkg::ADDR_SP, 8'h00, "pointer");
    rd_chk(pcs_pkg::ADDR_STAT, 8'h01, "status");
    wr(pcs_pkg::ADDR_STAT, 8'h00);
    do_op(pcs_pkg::OP_RETURN, 21'h000000);
    `CHK("reset pulses", 2, rst_cnt)
    rd_chk(pcs_pkg::ADDR_STAT, 8'h02, "status");
    wr(pcs_pkg::ADDR_STAT, 8'h01);
    rd_chk(pcs_pkg::ADDR_STAT, 8'h01, "status");
    `CHK("reset pulses", 2, rst_cnt)
    do_op(pcs_pkg::OP_PUSH, 21'h000000);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(pcs_pkg::ADDR_SP, 8'h00, "pointer");
    wr(8'h21, 8'h01);
    `CHK("write resp", pcs_pkg::RESP_SLVERR, rsp)
    rd_chk(8'h20, 8'h00, "unmapped");
    `CHK("read resp", pcs_pkg::RESP_SLVERR, rsp)
    cfg.app_write_protect <= 1'b1;
    flc(21'h000100, 1'b0);
    cfg.app_write_protect <= 1'b0;
    flc(21'h000100, 1'b1);
    cfg.boot_region_enable_n <= 1'b0;
    cfg.boot_write_protect <= 1'b1;
    flc(21'h0003FE, 1'b0);
    flc(21'h000400, 1'b1);
    cfg.storage_region_enable_n <= 1'b0;
    cfg.storage_write_protect <= 1'b1;
    flc(21'h01FF00, 1'b0);
    flc(21'h01FEFE, 1'b1);
    do_op(pcs_pkg::OP_JUMP, 21'h01FF00);
    `CHK("fetch fault", 1'b1, fetch_fault)
    do_op(pcs_pkg::OP_JUMP, 21'h01FEFE);
    `CHK("fetch fault", 1'b0, fetch_fault)
    close_out();
  end
endmodule // testbench
`default_nettype wire
